// ### verilog/async_port_pkg.sv
package async_port_pkg;

	// ****************************************
	// Sizes and register map
	// ****************************************
	localparam int        ADDR_W        = 10;
	localparam int        DATA_W        = 16;
	localparam int        EVENT_W       = 8;
	localparam logic [9:0] REG_CTRL     = 10'h000;
	localparam logic [9:0] REG_INT_EN   = 10'h001;
	localparam logic [9:0] REG_INT_STAT = 10'h002;
	localparam logic [9:0] REG_SCRATCH  = 10'h003;
	localparam int        CTRL_DRIVE_HI = 0;
	localparam logic [15:0] CTRL_RESET  = 16'h0000;
	localparam logic [7:0] INT_EN_RESET = 8'h00;
	localparam logic      STYLE_DATA_STROBE = 1'b1;
	localparam logic      WIDTH_WIDE    = 1'b1;

	// ****************************************
	// State encodings
	// ****************************************
	typedef enum logic [2:0]
	{
		D_IDLE = 3'b001,
		D_WAIT = 3'b010,
		D_DONE = 3'b100
	} dev_state_t;

	typedef enum logic [3:0]
	{
		H_IDLE    = 4'b0001,
		H_ADDR    = 4'b0010,
		H_STROBE  = 4'b0100,
		H_RELEASE = 4'b1000
	} host_state_t;

	// Strobe pins to read request
	function automatic logic strobe_is_read(input logic style, input logic s1_n,
		input logic s2);
	begin
		strobe_is_read = (style == STYLE_DATA_STROBE) ? s2 : ~s1_n;
	end
	endfunction

	// Strobe pins to any access
	function automatic logic strobe_active(input logic style, input logic s1_n,
		input logic s2_n);
	begin
		strobe_active = (style == STYLE_DATA_STROBE) ? ~s1_n : (~s1_n | ~s2_n);
	end
	endfunction

endpackage

// ### verilog/async_port_if.sv
`timescale 1ns/1ps
// ****************************************
// Host port wires between the two ends
// ****************************************
interface async_port_if;
	logic [9:0]  addr;      // Word address
	logic        lane_swap; // Byte select or lane swap
	logic        ale;       // Address latch strobe
	logic        cs_n;      // Chip select
	logic        rd_n;      // Read strobe or data strobe
	logic        wr_n;      // Write strobe or direction
	logic        mode;      // Strobe style strap
	logic        width;     // Bus width strap
	logic [15:0] d_host;    // Host data out
	logic [1:0]  d_host_oe; // Host lane enables
	logic [15:0] d_dev;     // Device data out
	logic [1:0]  d_dev_oe;  // Device lane enables
	logic        rdy_n;     // Ready value
	logic        rdy_oe;    // Ready enable
	logic        int_n;     // Interrupt value
	logic        int_oe;    // Interrupt enable
	logic [15:0] d_bus;     // Resolved data, pulled high
	logic        rdy_bus;   // Resolved ready, pulled high
	logic        int_bus;   // Resolved interrupt, pulled high

	// Weak pullups stand in for floating lines
	assign d_bus[7:0]  = d_dev_oe[0] ? d_dev[7:0] :
		(d_host_oe[0] ? d_host[7:0] : 8'hff);
	assign d_bus[15:8] = d_dev_oe[1] ? d_dev[15:8] :
		(d_host_oe[1] ? d_host[15:8] : 8'hff);
	assign rdy_bus = rdy_oe ? rdy_n : 1'b1;
	assign int_bus = int_oe ? int_n : 1'b1;

	modport dev  (input addr, lane_swap, ale, cs_n, rd_n, wr_n, mode, width, d_bus,
		output d_dev, d_dev_oe, rdy_n, rdy_oe, int_n, int_oe);
	modport host (output addr, lane_swap, ale, cs_n, rd_n, wr_n, mode, width,
		d_host, d_host_oe, input d_bus, rdy_bus, int_bus);
endinterface

// ### verilog/async_port_dev.sv
`timescale 1ns/1ps
module async_port_dev
(
	// Clock and reset
	input  wire logic                              CORE_CLK_I,
	input  wire logic                              RESET_I,
	// Interrupt source events
	input  wire logic [async_port_pkg::EVENT_W-1:0] EVENT_I,
	// Register view for the core
	output logic      [15:0]                       SCRATCH_O,
	// Host port
	async_port_if.dev                              bus
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed
	{
		async_port_pkg::dev_state_t state; // Access sequencer
		logic [9:0]  addr_lat;             // Held address
		logic [9:0]  addr;                 // Address of access
		logic        a0;                   // Byte select or swap
		logic        rd;                   // Access is a read
		logic [15:0] rdata;                // Read data lanes
		logic [15:0] ctrl;                 // Control register
		logic [7:0]  int_en;               // Source enables
		logic [7:0]  int_stat;             // Sticky sources
		logic [15:0] scratch;              // Free register
	} dev_s_t;

	dev_s_t s_reg;  // Current state
	dev_s_t s_next; // Next state

	logic        access;   // Chip selected with strobe
	logic        is_read;  // Direction now on pins
	logic [9:0]  eff_addr; // Address after latch
	logic [15:0] reg_val;  // Register chosen by address
	logic [15:0] wr_val;   // Merged write value
	logic [15:0] wr_clr;   // Write value over zero
	logic        int_act;  // Any enabled source active

	// ****************************************
	// Lane steering
	// ****************************************
	// Register to pins
	// width strap picks lanes
	function automatic logic [15:0] lane_out(input logic [15:0] v, input logic wide,
		input logic a0);
	begin
		if (wide == async_port_pkg::WIDTH_WIDE)
			lane_out = a0 ? {v[7:0], v[15:8]} : v;
		else
			lane_out = {8'h00, (a0 ? v[15:8] : v[7:0])};
	end
	endfunction

	// Pins into register, narrow keeps other byte
	function automatic logic [15:0] lane_in(input logic [15:0] d, input logic wide,
		input logic a0, input logic [15:0] old);
	begin
		if (wide == async_port_pkg::WIDTH_WIDE)
			lane_in = a0 ? {d[7:0], d[15:8]} : d;
		else
			lane_in = a0 ? {d[7:0], old[7:0]} : {old[15:8], d[7:0]};
	end
	endfunction

	// ****************************************
	// Decode
	// ****************************************
	// Pin decode and register select
	always_comb
	begin
		access  = ~bus.cs_n & async_port_pkg::strobe_active(bus.mode, bus.rd_n, bus.wr_n);
		is_read = async_port_pkg::strobe_is_read(bus.mode, bus.rd_n, bus.wr_n);
		eff_addr = bus.ale ? bus.addr : s_reg.addr_lat;
		case (s_reg.addr)
			async_port_pkg::REG_CTRL:     reg_val = s_reg.ctrl;
			async_port_pkg::REG_INT_EN:   reg_val = {8'h00, s_reg.int_en};
			async_port_pkg::REG_INT_STAT: reg_val = {8'h00, s_reg.int_stat};
			async_port_pkg::REG_SCRATCH:  reg_val = s_reg.scratch;
			// Unmapped words read as zero
			default:                      reg_val = 16'h0000;
		endcase
		wr_val  = lane_in(bus.d_bus, bus.width, s_reg.a0, reg_val);
		wr_clr  = lane_in(bus.d_bus, bus.width, s_reg.a0, 16'h0000);
		int_act = |(s_reg.int_stat & s_reg.int_en);
	end

	// ****************************************
	// Next state
	// ****************************************
	// Sequencer and registers
	always_comb
	begin
		s_next = s_reg;
		// follow while high, hold while low
		if (bus.ale)
			s_next.addr_lat = bus.addr;
		// New events win over a clear below
		s_next.int_stat = s_reg.int_stat | EVENT_I;
		case (s_reg.state)
			async_port_pkg::D_IDLE:
			begin
				if (access)
				begin
					s_next.addr  = eff_addr;
					s_next.a0    = bus.lane_swap;
					s_next.rd    = is_read;
					s_next.state = async_port_pkg::D_WAIT;
				end
			end
			async_port_pkg::D_WAIT:
			begin
				// Dropped access is abandoned
				if (!access)
					s_next.state = async_port_pkg::D_IDLE;
				else
				begin
					s_next.state = async_port_pkg::D_DONE;
					if (s_reg.rd)
					begin
						s_next.rdata = lane_out(reg_val, bus.width, s_reg.a0);
					end
					else
					begin
						case (s_reg.addr)
							async_port_pkg::REG_CTRL:     s_next.ctrl = wr_val;
							async_port_pkg::REG_INT_EN:   s_next.int_en = wr_val[7:0];
							async_port_pkg::REG_INT_STAT:
								s_next.int_stat = (s_reg.int_stat & ~wr_clr[7:0]) | EVENT_I;
							async_port_pkg::REG_SCRATCH:  s_next.scratch = wr_val;
							// Unmapped writes dropped
							default:                      s_next.scratch = s_reg.scratch;
						endcase
					end
				end
			end
			async_port_pkg::D_DONE:
			begin
				if (!access)
					s_next.state = async_port_pkg::D_IDLE;
			end
			default:
				s_next.state = async_port_pkg::D_IDLE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	// Single state register
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
		begin
			s_reg          <= '0;
			s_reg.state    <= async_port_pkg::D_IDLE;
			s_reg.ctrl     <= async_port_pkg::CTRL_RESET;
			s_reg.int_en   <= async_port_pkg::INT_EN_RESET;
		end
		else
			s_reg <= s_next;
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	logic drive_rd; // Read answer on the pins

	// Data and ready enables follow live pins so release floats at once
	always_comb
	begin
		drive_rd = ~RESET_I & ~bus.cs_n & access & is_read & s_reg.rd &
			(s_reg.state == async_port_pkg::D_DONE);
		bus.d_dev       = s_reg.rdata;
		bus.d_dev_oe[0] = drive_rd;
		// upper lane only on wide bus
		bus.d_dev_oe[1] = drive_rd & (bus.width == async_port_pkg::WIDTH_WIDE);
		bus.rdy_n  = (s_reg.state != async_port_pkg::D_DONE);
		bus.rdy_oe = ~RESET_I & ~bus.cs_n;
		bus.int_n  = ~int_act;
		bus.int_oe = ~RESET_I & (int_act | s_reg.ctrl[async_port_pkg::CTRL_DRIVE_HI]);
		SCRATCH_O  = s_reg.scratch;
	end

endmodule

// ### verilog/async_port_host.sv
`timescale 1ns/1ps
module async_port_host
#(
	parameter logic SMALL_PART = 1'b0 // Top address pin tied low
)
(
	// Clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        RESET_I,
	// Board straps
	input  wire logic        MODE_I,
	input  wire logic        WIDTH_I,
	input  wire logic        MUXED_I,
	// Command
	input  wire logic        CMD_READ_I,
	input  wire logic        CMD_WRITE_I,
	input  wire logic [9:0]  CMD_ADDR_I,
	input  wire logic        CMD_LANE_I,
	input  wire logic [15:0] CMD_WDATA_I,
	// Answer
	output logic             BUSY_O,
	output logic             DONE_O,
	output logic      [15:0] RDATA_O,
	output logic             INT_O,
	// Host port
	async_port_if.host       bus
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed
	{
		async_port_pkg::host_state_t state; // Cycle sequencer
		logic        rd;                    // Access is a read
		logic [9:0]  addr;                  // Word address
		logic        lane;                  // Byte select or swap
		logic [15:0] wdata;                 // Write data
		logic [15:0] rdata;                 // Last read data
		logic        done;                  // Completion pulse
	} host_s_t;

	host_s_t s_reg;  // Current state
	host_s_t s_next; // Next state

	// ****************************************
	// Next state
	// ****************************************
	// Sequencer
	always_comb
	begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		case (s_reg.state)
			async_port_pkg::H_IDLE:
			begin
				// Read wins if both asked
				if (CMD_READ_I | CMD_WRITE_I)
				begin
					s_next.rd    = CMD_READ_I;
					s_next.addr  = {CMD_ADDR_I[9] & ~SMALL_PART, CMD_ADDR_I[8:0]};
					s_next.lane  = CMD_LANE_I;
					s_next.wdata = CMD_WDATA_I;
					s_next.state = MUXED_I ? async_port_pkg::H_ADDR :
						async_port_pkg::H_STROBE;
				end
			end
			async_port_pkg::H_ADDR:
				s_next.state = async_port_pkg::H_STROBE;
			async_port_pkg::H_STROBE:
			begin
				// Wait for ready low, no timeout
				if (bus.rdy_bus == 1'b0)
				begin
					if (s_reg.rd)
						s_next.rdata = (WIDTH_I == async_port_pkg::WIDTH_WIDE) ?
							bus.d_bus : {8'h00, bus.d_bus[7:0]};
					s_next.state = async_port_pkg::H_RELEASE;
				end
			end
			async_port_pkg::H_RELEASE:
			begin
				s_next.done  = 1'b1;
				s_next.state = async_port_pkg::H_IDLE;
			end
			default:
				s_next.state = async_port_pkg::H_IDLE;
		endcase
	end

	// Single state register
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
		begin
			s_reg       <= '0;
			s_reg.state <= async_port_pkg::H_IDLE;
		end
		else
			s_reg <= s_next;
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	logic in_cycle; // Strobe phase

	// Pins decoded from state
	always_comb
	begin
		in_cycle      = (s_reg.state == async_port_pkg::H_STROBE);
		bus.mode      = MODE_I;
		bus.width     = WIDTH_I;
		// latch strobe high when not muxed
		bus.ale       = ~MUXED_I | (s_reg.state == async_port_pkg::H_ADDR);
		// Muxed lines carry no address after latching
		bus.addr      = (MUXED_I & ~bus.ale) ? 10'h000 : s_reg.addr;
		bus.lane_swap = s_reg.lane;
		bus.cs_n      = ~in_cycle;
		if (MODE_I == async_port_pkg::STYLE_DATA_STROBE)
		begin
			bus.rd_n = ~in_cycle;
			bus.wr_n = s_reg.rd;
		end
		else
		begin
			bus.rd_n = ~(in_cycle & s_reg.rd);
			bus.wr_n = ~(in_cycle & ~s_reg.rd);
		end
		bus.d_host       = s_reg.wdata;
		bus.d_host_oe[0] = in_cycle & ~s_reg.rd;
		// upper lane only on wide bus
		bus.d_host_oe[1] = in_cycle & ~s_reg.rd & (WIDTH_I == async_port_pkg::WIDTH_WIDE);
		BUSY_O  = (s_reg.state != async_port_pkg::H_IDLE);
		DONE_O  = s_reg.done;
		RDATA_O = s_reg.rdata;
		INT_O   = ~bus.int_bus;
	end

endmodule

// ### dv/async_port_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Pin checks on the shared host port
// ****************************************
module async_port_asserts
(
	// Clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        RESET_I,
	// Host driven pins
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        mode,
	input  wire logic        width,
	// Device driven pins
	input  wire logic [15:0] d_dev,
	input  wire logic [1:0]  d_dev_oe,
	input  wire logic        rdy_n,
	input  wire logic        rdy_oe,
	input  wire logic        int_oe
);
	// Selected and strobed, either style
	logic act;
	// Read direction, either style
	logic is_rd;

	// Decode kept here so a wrong decode in the device disagrees
	assign act   = !cs_n && (mode ? !rd_n : (!rd_n || !wr_n));
	assign is_rd = mode ? wr_n : !rd_n;

	// One domain, so clock and reset are given once
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);

	a_desel_data_float: assert property (cs_n |-> d_dev_oe == 2'b00)
		else $error("data lanes driven while deselected");
	a_wide_both_lanes: assert property ((width && d_dev_oe != 2'b00) |-> d_dev_oe == 2'b11)
		else $error("wide read drives only one lane");
	a_read_drives_data: assert property ((act && is_rd && rdy_oe && !rdy_n) |-> d_dev_oe != 2'b00)
		else $error("ready read without data driven");
	a_write_no_drive: assert property ((act && !is_rd) |-> d_dev_oe == 2'b00)
		else $error("device drives data during a write");
	a_narrow_upper_off: assert property (!width |-> !d_dev_oe[1])
		else $error("upper lane driven on narrow bus");
	a_ready_desel_float: assert property (cs_n |-> !rdy_oe)
		else $error("ready driven while deselected");
	// Answer: high for two cycles, then low
	a_ready_answer_time: assert property ($rose(act) |-> (rdy_oe && rdy_n) ##1
		(rdy_oe && rdy_n) ##1 (rdy_oe && !rdy_n))
		else $error("ready timing wrong");
	a_ready_low_holds: assert property ((act && rdy_oe && !rdy_n) |=>
		(!act || (rdy_oe && !rdy_n)))
		else $error("ready dropped during access");
	a_read_data_stable: assert property ((act && d_dev_oe != 2'b00) |=>
		(!act || $stable(d_dev)))
		else $error("read data moved during access");
	a_int_idle_float: assert property ($fell(RESET_I) |-> !int_oe)
		else $error("interrupt driven after reset");
endmodule

// ### dv/tb_async_host_register_port.sv
`timescale 1ns/1ps
// ****************************************
// Compare macro, counts every check
// ****************************************
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_async_host_register_port;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic        core_clk    = 1'b0;    // 25 MHz core clock
	logic        reset       = 1'b1;    // Held high at start
	logic        strap_mode  = 1'b0;    // Strobe style strap
	logic        strap_width = 1'b1;    // Bus width strap
	logic        strap_muxed = 1'b0;    // Latch strobe use
	logic        cmd_read    = 1'b0;    // Read request
	logic        cmd_write   = 1'b0;    // Write request
	logic [9:0]  cmd_addr    = 10'h000; // Word address
	logic        cmd_lane    = 1'b0;    // Byte select or swap
	logic [15:0] cmd_wdata   = 16'h0000; // Write data
	logic [7:0]  events      = 8'h00;   // Interrupt sources
	logic        busy;                  // Host cycle running
	logic        done;                  // Host cycle finished
	logic        int_hit;               // Interrupt seen
	logic [15:0] rdata;                 // Last read data
	logic [15:0] scratch;               // Core view of scratch
	logic [15:0] rq;                    // Read result
	int          error_cnt   = 0;       // Mismatches
	int          checks      = 0;       // Comparisons

	// Free running clock
	always #20 core_clk = ~core_clk;

	// ****************************************
	// Both ends, the wires and the checker
	// ****************************************
	async_port_if port_if ();
	async_port_dev u_async_port_dev (.CORE_CLK_I(core_clk), .RESET_I(reset), .EVENT_I(events),
		.SCRATCH_O(scratch), .bus(port_if));
	async_port_host #(.SMALL_PART(1'b0)) u_async_port_host (.CORE_CLK_I(core_clk),
		.RESET_I(reset), .MODE_I(strap_mode), .WIDTH_I(strap_width), .MUXED_I(strap_muxed),
		.CMD_READ_I(cmd_read), .CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr),
		.CMD_LANE_I(cmd_lane), .CMD_WDATA_I(cmd_wdata), .BUSY_O(busy), .DONE_O(done),
		.RDATA_O(rdata), .INT_O(int_hit), .bus(port_if));
	async_port_asserts u_async_port_asserts (.CORE_CLK_I(core_clk), .RESET_I(reset),
		.cs_n(port_if.cs_n), .rd_n(port_if.rd_n), .wr_n(port_if.wr_n), .mode(port_if.mode),
		.width(port_if.width), .d_dev(port_if.d_dev), .d_dev_oe(port_if.d_dev_oe),
		.rdy_n(port_if.rdy_n), .rdy_oe(port_if.rdy_oe), .int_oe(port_if.int_oe));

	// ****************************************
	// Tasks
	// ****************************************
	// Verdict and end of run
	task automatic report_and_stop;
	begin
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask

	// Reset with new straps; straps only change while in reset
	task automatic do_reset(input logic [2:0] cfg);
	begin
		@(posedge core_clk);
		reset <= 1'b1;
		{strap_muxed, strap_width, strap_mode} <= cfg;
		repeat (10) @(posedge core_clk);
		#1;
		`CHK(port_if.int_oe, 1'b0)
		`CHK(port_if.d_dev_oe, 2'b00)
		@(posedge core_clk);
		reset <= 1'b0;
	end
	endtask

	// One command; answer time is fixed by the strap
	task automatic xfer(input logic rd, input logic [9:0] a, input logic ln,
		input logic [15:0] wd);
		int n;
	begin
		n = 0;
		@(posedge core_clk);
		cmd_read  <= rd;
		cmd_write <= !rd;
		cmd_addr  <= a;
		cmd_lane  <= ln;
		cmd_wdata <= wd;
		@(posedge core_clk);
		cmd_read  <= 1'b0;
		cmd_write <= 1'b0;
		// Command taken at this edge, so the host is busy now
		#1;
		`CHK(busy, 1'b1)
		// Bounded wait: a hang shows as a wrong count
		do
		begin
			@(posedge core_clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 12);
		`CHK(n, (strap_muxed ? 5 : 4))
		`CHK(busy, 1'b0)
		rq = rdata;
	end
	endtask

	// Read and compare
	task automatic rd_chk(input logic [9:0] a, input logic ln, input logic [15:0] exp);
	begin
		xfer(1'b1, a, ln, 16'h0000);
		`CHK(rq, exp)
	end
	endtask

	// Single interrupt event pulse
	task automatic pulse(input logic [7:0] ev);
	begin
		@(posedge core_clk);
		events <= ev;
		@(posedge core_clk);
		events <= 8'h00;
		repeat (2) @(posedge core_clk);
		#1;
	end
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		// Every style, width and latch use in turn
		for (int c = 0; c < 8; c++)
		begin
			do_reset(c[2:0]);
			`CHK(port_if.d_bus, 16'hffff)
			rd_chk(async_port_pkg::REG_CTRL, 1'b0, 16'h0000);
			rd_chk(async_port_pkg::REG_INT_EN, 1'b0, 16'h0000);
			if (c[1])
			begin
				// Wide bus: natural order, then swapped both ways
				xfer(1'b0, async_port_pkg::REG_SCRATCH, 1'b0, 16'ha5c3);
				`CHK(scratch, 16'ha5c3)
				rd_chk(async_port_pkg::REG_SCRATCH, 1'b1, 16'hc3a5);
				xfer(1'b0, async_port_pkg::REG_SCRATCH, 1'b1, 16'h1234);
				`CHK(scratch, 16'h3412)
				rd_chk(async_port_pkg::REG_SCRATCH, 1'b0, 16'h3412);
			end
			else
			begin
				// Narrow bus: one byte per access
				xfer(1'b0, async_port_pkg::REG_SCRATCH, 1'b0, 16'h005a);
				xfer(1'b0, async_port_pkg::REG_SCRATCH, 1'b1, 16'h0096);
				`CHK(scratch, 16'h965a)
				rd_chk(async_port_pkg::REG_SCRATCH, 1'b1, 16'h0096);
				rd_chk(async_port_pkg::REG_SCRATCH, 1'b0, 16'h005a);
			end
			// Unmapped addresses; 10'h203 keeps its top bit and does not alias
			xfer(1'b0, 10'h3ff, 1'b0, 16'h7777);
			rd_chk(10'h3ff, 1'b0, 16'h0000);
			rd_chk(10'h203, 1'b0, 16'h0000);
		end
		// Interrupt: masked, enabled, cleared, driven high
		do_reset(3'b010);
		pulse(8'h04);
		`CHK(port_if.int_bus, 1'b1)
		rd_chk(async_port_pkg::REG_INT_STAT, 1'b0, 16'h0004);
		xfer(1'b0, async_port_pkg::REG_INT_EN, 1'b0, 16'h0004);
		`CHK(port_if.int_bus, 1'b0)
		`CHK(int_hit, 1'b1)
		xfer(1'b0, async_port_pkg::REG_INT_STAT, 1'b0, 16'h0004);
		`CHK(port_if.int_oe, 1'b0)
		xfer(1'b0, async_port_pkg::REG_CTRL, 1'b0, 16'h0001);
		`CHK(port_if.int_oe, 1'b1)
		`CHK(port_if.int_bus, 1'b1)
		pulse(8'h80);
		`CHK(port_if.int_bus, 1'b1)
		// Reset must float the line although it was driven
		do_reset(3'b010);
		#1;
		`CHK(port_if.int_oe, 1'b0)
		report_and_stop;
	end

	// Watchdog: the tests need far less than 10000 cycles
	initial
	begin
		#400000;
		error_cnt++;
		report_and_stop;
	end
endmodule
